// >>> hdl/chg_counter.sv
// Charge counter control, averaged current, end-of-charge check and AHB-Lite registers
// Operation
// - Resolution field scales counts 100-1000 mC
// - Decimator steps counter at programmed scale
// - Reset bit clears logic, self-clears within 40us
// - Run bit starts; clearing holds count
// - Offset correction (chopping) on unless disabled
// - Calibration bit shorts converter inputs
// - Dither applies only with correction enabled
// - End-of-charge when current reaches threshold
// - End-of-charge mode forces run, ignores reset
// - Settings stay writable during end-of-charge
// - Fault flag on overflow, write-one clear
// - Fault when counter equals 0x8000
// - Read-only 12-bit average battery current
// - Period select 4/8/16/32 s, 8 s default
// - Current LSB 25 mA at 100 mC, 4 s
`timescale 1ns/1ps
module chg_counter
  import chg_pkg::*;
#(
  parameter int unsigned BASE_PERIOD_CYC = BASE_PERIOD_S * 100000000
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic adc_bit,
  input wire logic eoc_mode,
  output logic charge_complete,
  output logic input_short,
  output logic dither_enable,
  output logic chop,
  output logic irq
);
  chg_dec_if dif ();

  logic adc_meta_ff;
  logic adc_sync_ff;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic run_bit_ff;
  logic cdis_ff;
  logic acal_ff;
  logic dith_ff;
  logic dith_out_ff;
  logic [1:0] res_ff;
  logic [1:0] integ_ff;
  logic [14:0] scale_ff;
  logic [11:0] thr_ff;
  logic [1:0] imask_ff;
  logic [1:0] istat_ff;
  logic irq_ff;
  logic fault_ff;
  logic chop_ff;
  logic [12:0] rst_cnt_ff;
  chg_state_t state_ff;
  chg_state_t nxt_state;
  logic signed [4:0] pre_ff;
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic [15:0] snap_ff;
  logic [11:0] curr_ff;
  logic [33:0] tmr_ff;
  logic [33:0] period_cyc;
  logic period_end;
  logic eoc_seen_ff;
  logic eoc_done_ff;
  logic run_eff;
  logic ap_take;
  logic wr_ctrl;
  logic rst_req;
  logic cnt_up;
  logic cnt_dn;
  logic signed [15:0] delta;
  logic [31:0] rd_mux;
  logic [4:0] mult;

  // Converter bitstream is asynchronous to clk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      adc_meta_ff <= 1'b0;
      adc_sync_ff <= 1'b0;
    end else begin
      adc_meta_ff <= adc_bit;
      adc_sync_ff <= adc_meta_ff;
    end
  end

  // Chopping flips converter polarity each sample; undoing it cancels offset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chop_ff <= 1'b0;
    end else begin
      chop_ff <= ~cdis_ff & ~chop_ff;
    end
  end

  // AHB-Lite bus: zero wait states, always OKAY
  assign ap_take = hsel & htrans[1] & hready;
  assign wr_ctrl = wr_pend_ff && wr_addr_ff == ADR_CTRL;
  assign rst_req = wr_ctrl & hwdata[CTL_RST] & ~eoc_mode;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hreadyout_ff <= 1'b0;
    end else begin
      wr_pend_ff <= ap_take & hwrite;
      wr_addr_ff <= haddr[7:0];
      hreadyout_ff <= 1'b1;
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    case (haddr[7:0])
      ADR_CTRL: begin
        rd_mux[CTL_RST] = state_ff == CHG_CLEAR;
        rd_mux[CTL_RUN] = run_bit_ff;
        rd_mux[CTL_CDIS] = cdis_ff;
        rd_mux[CTL_ACAL] = acal_ff;
        rd_mux[CTL_DITH] = dith_ff;
        rd_mux[CTL_RES_LO +: 2] = res_ff;
        rd_mux[CTL_INT_LO +: 2] = integ_ff;
      end
      ADR_SCALE: rd_mux[14:0] = scale_ff;
      ADR_COUNT: rd_mux[15:0] = count_ff;
      ADR_FAULT: rd_mux[0] = fault_ff;
      ADR_CURR: rd_mux[11:0] = curr_ff;
      ADR_THR: rd_mux[11:0] = thr_ff;
      ADR_ISTAT: rd_mux[1:0] = istat_ff;
      ADR_IMASK: rd_mux[1:0] = imask_ff;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata_ff <= 32'h00000000;
    end else if (ap_take & ~hwrite) begin
      hrdata_ff <= rd_mux;
    end
  end

  // Settings stay writable in every mode, end-of-charge included
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_bit_ff <= 1'b0;
      cdis_ff <= 1'b0;
      acal_ff <= 1'b0;
      dith_ff <= 1'b0;
      res_ff <= RES_RST;
      integ_ff <= INTEG_RST;
    end else if (wr_ctrl) begin
      run_bit_ff <= hwdata[CTL_RUN];
      cdis_ff <= hwdata[CTL_CDIS];
      acal_ff <= hwdata[CTL_ACAL];
      dith_ff <= hwdata[CTL_DITH];
      res_ff <= hwdata[CTL_RES_LO +: 2];
      integ_ff <= hwdata[CTL_INT_LO +: 2];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scale_ff <= SCALE_RST;
      thr_ff <= THR_RST;
      imask_ff <= 2'h0;
    end else if (wr_pend_ff) begin
      if (wr_addr_ff == ADR_SCALE) begin
        scale_ff <= hwdata[14:0];
      end
      if (wr_addr_ff == ADR_THR) begin
        thr_ff <= hwdata[11:0];
      end
      if (wr_addr_ff == ADR_IMASK) begin
        imask_ff <= hwdata[1:0];
      end
    end
  end

  // Converter-side controls
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dith_out_ff <= 1'b0;
    end else begin
      dith_out_ff <= dith_ff & ~cdis_ff;
    end
  end

  // Run/clear sequencing; end-of-charge mode keeps counting
  assign run_eff = run_bit_ff | eoc_mode;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CHG_CLEAR: begin
        if (rst_cnt_ff == RESET_CYC_V - 13'h0001) begin
          nxt_state = run_eff ? CHG_RUN : CHG_HALT;
        end
      end
      CHG_RUN: begin
        if (rst_req) begin
          nxt_state = CHG_CLEAR;
        end else if (!run_eff) begin
          nxt_state = CHG_HALT;
        end
      end
      CHG_HALT: begin
        if (rst_req) begin
          nxt_state = CHG_CLEAR;
        end else if (run_eff) begin
          nxt_state = CHG_RUN;
        end
      end
      default: nxt_state = CHG_HALT;
    endcase
    if (eoc_mode && state_ff == CHG_CLEAR) begin
      nxt_state = CHG_RUN;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= CHG_HALT;
      rst_cnt_ff <= 13'h0000;
    end else begin
      state_ff <= nxt_state;
      rst_cnt_ff <= (state_ff == CHG_CLEAR) ? rst_cnt_ff + 13'h0001 : 13'h0000;
    end
  end

  assign dif.sample = adc_sync_ff ^ chop_ff;
  assign dif.run = state_ff == CHG_RUN;
  assign dif.clear = state_ff == CHG_CLEAR;
  assign dif.scale = scale_ff;

  chg_decim u_decim (
    .clk(clk),
    .rst(rst),
    .d(dif)
  );

  // Resolution prescaler between decimator steps and charge counts
  assign mult = chg_res_mult(res_ff);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_ff <= 5'sh00;
    end else if (dif.clear || cnt_up || cnt_dn) begin
      pre_ff <= 5'sh00;
    end else if (dif.step_up) begin
      pre_ff <= pre_ff + 5'sh01;
    end else if (dif.step_dn) begin
      pre_ff <= pre_ff - 5'sh01;
    end
  end

  assign cnt_up = dif.step_up && pre_ff + 5'sh01 >= signed'(mult);
  assign cnt_dn = dif.step_dn && pre_ff - 5'sh01 <= -signed'(mult);

  always_comb begin
    nxt_count = count_ff;
    if (cnt_up) begin
      nxt_count = count_ff + 16'h0001;
    end else if (cnt_dn) begin
      nxt_count = count_ff - 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_ff <= 16'h0000;
    end else if (dif.clear) begin
      count_ff <= 16'h0000;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // Fault: landing on 0x8000 or leaving it in either direction; set beats clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_ff <= 1'b0;
    end else if ((cnt_up || cnt_dn) &&
                 (nxt_count == COUNT_ROLL || count_ff == COUNT_ROLL)) begin
      fault_ff <= 1'b1;
    end else if (wr_pend_ff && wr_addr_ff == ADR_FAULT && hwdata[0]) begin
      fault_ff <= 1'b0;
    end
  end

  // Averaging period: count delta over period, LSB = resolution / period
  assign period_cyc = 34'(BASE_PERIOD_CYC) << integ_ff;
  assign period_end = dif.run && tmr_ff >= period_cyc - 34'h000000001;
  assign delta = signed'(count_ff - snap_ff);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmr_ff <= 34'h000000000;
      snap_ff <= 16'h0000;
      curr_ff <= 12'h000;
    end else if (dif.clear) begin
      tmr_ff <= 34'h000000000;
      snap_ff <= 16'h0000;
    end else if (period_end) begin
      tmr_ff <= 34'h000000000;
      snap_ff <= count_ff;
      curr_ff <= delta[11:0];
    end else if (dif.run) begin
      tmr_ff <= tmr_ff + 34'h000000001;
    end
  end

  // First period in the mode may be partial, so it is not judged
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eoc_seen_ff <= 1'b0;
      eoc_done_ff <= 1'b0;
    end else if (!eoc_mode) begin
      eoc_seen_ff <= 1'b0;
      eoc_done_ff <= 1'b0;
    end else if (period_end) begin
      eoc_seen_ff <= 1'b1;
      if (eoc_seen_ff && delta <= signed'({4'h0, thr_ff})) begin
        eoc_done_ff <= 1'b1;
      end
    end
  end

  // Interrupt status: set beats write-one clear; fault has no interrupt
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      istat_ff <= 2'h0;
      irq_ff <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_pend_ff && wr_addr_ff == ADR_ISTAT && hwdata[i]) begin
          istat_ff[i] <= 1'b0;
        end
      end
      if (period_end) begin
        istat_ff[IRQ_PERIOD] <= 1'b1;
      end
      if (period_end && eoc_mode && eoc_seen_ff && !eoc_done_ff &&
          delta <= signed'({4'h0, thr_ff})) begin
        istat_ff[IRQ_EOC] <= 1'b1;
      end
      irq_ff <= |(istat_ff & imask_ff);
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = 1'b0;
  assign charge_complete = eoc_done_ff;
  assign input_short = acal_ff;
  assign dither_enable = dith_out_ff;
  assign chop = chop_ff;
  assign irq = irq_ff;
endmodule : chg_counter

// >>> hdl/chg_dec_if.sv
// Interface between the counter control and the bitstream decimator
`timescale 1ns/1ps
interface chg_dec_if;
  logic sample;
  logic run;
  logic clear;
  logic [14:0] scale;
  logic step_up;
  logic step_dn;
  modport ctl (output sample, run, clear, scale, input step_up, step_dn);
  modport dec (input sample, run, clear, scale, output step_up, step_dn);
endinterface : chg_dec_if

// >>> hdl/chg_decim.sv
// Up/down decimator turning the converter bitstream into unit steps
`timescale 1ns/1ps
module chg_decim
  import chg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  chg_dec_if.dec d
);
  logic signed [16:0] acc_ff;
  logic signed [16:0] nxt_acc;
  logic signed [16:0] lim;
  logic step_up_ff;
  logic step_dn_ff;

  always_comb begin
    // Zero scale would step every sample in both signs; treat it as one
    lim = (d.scale == 15'h0000) ? 17'sh00001 : signed'({2'b00, d.scale});
    nxt_acc = acc_ff + (d.sample ? 17'sh00001 : -17'sh00001);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_ff <= 17'sh00000;
      step_up_ff <= 1'b0;
      step_dn_ff <= 1'b0;
    end else if (d.clear) begin
      acc_ff <= 17'sh00000;
      step_up_ff <= 1'b0;
      step_dn_ff <= 1'b0;
    end else if (d.run) begin
      step_up_ff <= nxt_acc >= lim;
      step_dn_ff <= nxt_acc <= -lim;
      if (nxt_acc >= lim || nxt_acc <= -lim) begin
        acc_ff <= 17'sh00000;
      end else begin
        acc_ff <= nxt_acc;
      end
    end else begin
      // Halted: contents kept for a later restart
      step_up_ff <= 1'b0;
      step_dn_ff <= 1'b0;
    end
  end

  assign d.step_up = step_up_ff;
  assign d.step_dn = step_dn_ff;
endmodule : chg_decim

// >>> hdl/chg_pkg.sv
// Package of register map, field layout and timing constants for the charge counter
package chg_pkg;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_SCALE = 8'h04;
  localparam logic [7:0] ADR_COUNT = 8'h08;
  localparam logic [7:0] ADR_FAULT = 8'h0C;
  localparam logic [7:0] ADR_CURR = 8'h10;
  localparam logic [7:0] ADR_THR = 8'h14;
  localparam logic [7:0] ADR_ISTAT = 8'h18;
  localparam logic [7:0] ADR_IMASK = 8'h1C;
  localparam int CTL_RST = 0;
  localparam int CTL_RUN = 1;
  localparam int CTL_CDIS = 2;
  localparam int CTL_ACAL = 3;
  localparam int CTL_DITH = 4;
  localparam int CTL_RES_LO = 5;
  localparam int CTL_INT_LO = 7;
  localparam int IRQ_PERIOD = 0;
  localparam int IRQ_EOC = 1;
  localparam logic [14:0] SCALE_RST = 15'h0111;
  localparam logic [1:0] RES_RST = 2'h0;
  localparam logic [1:0] INTEG_RST = 2'h1;
  localparam logic [11:0] THR_RST = 12'h000;
  localparam logic [15:0] COUNT_ROLL = 16'h8000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_TIME_NS = 40000;
  localparam int RESET_CYC = RESET_TIME_NS / CLK_PERIOD_NS;
  localparam logic [12:0] RESET_CYC_V = 13'(RESET_CYC);
  localparam int BASE_PERIOD_S = 4;

  typedef enum {CHG_HALT, CHG_CLEAR, CHG_RUN} chg_state_t;

  // Counts of decimator steps per charge count: 1, 2, 5, 10
  function automatic logic [4:0] chg_res_mult(input logic [1:0] sel);
    case (sel)
      2'h0: chg_res_mult = 5'h01;
      2'h1: chg_res_mult = 5'h02;
      2'h2: chg_res_mult = 5'h05;
      default: chg_res_mult = 5'h0A;
    endcase
  endfunction : chg_res_mult
endpackage : chg_pkg

// >>> test/chg_conv_model.sv
// Converter bitstream model: balanced idle pattern, ones or zeros bursts
`timescale 1ns/1ps
module chg_conv_model (
  input wire logic clk,
  input wire logic short_in,
  input wire logic [1:0] mode,
  output logic adc_bit
);
  logic tgl_ff = 1'b0;
  always @(posedge clk) tgl_ff <= ~tgl_ff;
  // Shorted inputs carry no signal, only the balanced pattern
  assign adc_bit = (short_in || mode == 2'h0) ? tgl_ff : (mode == 2'h1);
endmodule : chg_conv_model

// >>> test/chg_counter_sva.sv
// Checker on the charge counter ports
`timescale 1ns/1ps
module chg_counter_chk
  import chg_pkg::*;
#(
  parameter int unsigned BASE_PERIOD_CYC = 200
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic adc_bit,
  input wire logic eoc_mode,
  input wire logic charge_complete,
  input wire logic input_short,
  input wire logic dither_enable,
  input wire logic chop,
  input wire logic irq
);
  logic wr_ctl_ff, rd_ctl_ff, rd_cur_ff, rd_flt_ff, take;
  assign take = hsel && htrans[1] && hready;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ctl_ff <= 1'b0;
      rd_ctl_ff <= 1'b0;
      rd_cur_ff <= 1'b0;
      rd_flt_ff <= 1'b0;
    end else begin
      wr_ctl_ff <= take && hwrite && haddr[7:0] == ADR_CTRL;
      rd_ctl_ff <= take && !hwrite && haddr[7:0] == ADR_CTRL;
      rd_cur_ff <= take && !hwrite && haddr[7:0] == ADR_CURR;
      rd_flt_ff <= take && !hwrite && haddr[7:0] == ADR_FAULT;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_ctl_wr;
    wr_ctl_ff;
  endsequence
  property p_short;
    s_ctl_wr |=> input_short == $past(hwdata[CTL_ACAL]);
  endproperty
  a_short: assert property (p_short) else $error("short out of step");
  property p_hold;
    !wr_ctl_ff |=> $stable(input_short);
  endproperty
  a_hold: assert property (p_hold) else $error("short moved alone");
  // Dither only counts while correction stays on
  property p_dith;
    s_ctl_wr |=> ##1 dither_enable == ($past(hwdata[CTL_DITH], 2) && !$past(hwdata[CTL_CDIS], 2));
  endproperty
  a_dith: assert property (p_dith) else $error("dither wrong");
  property p_chop;
    dither_enable && $past(dither_enable) |-> chop != $past(chop);
  endproperty
  a_chop: assert property (p_chop) else $error("chop stuck");
  property p_cc_off;
    !eoc_mode |=> !charge_complete;
  endproperty
  a_cc_off: assert property (p_cc_off) else $error("complete outside mode");
  property p_cc_on;
    $rose(charge_complete) |-> $past(eoc_mode);
  endproperty
  a_cc_on: assert property (p_cc_on) else $error("complete without mode");
  property p_cur;
    rd_cur_ff |-> hrdata[31:12] == 20'h0;
  endproperty
  a_cur: assert property (p_cur) else $error("current too wide");
  property p_flt;
    rd_flt_ff |-> hrdata[31:1] == 31'h0;
  endproperty
  a_flt: assert property (p_flt) else $error("fault word wide");
  property p_ctl;
    rd_ctl_ff |-> hrdata[31:9] == 23'h0;
  endproperty
  a_ctl: assert property (p_ctl) else $error("control word wide");
endmodule : chg_counter_chk

bind chg_counter chg_counter_chk #(.BASE_PERIOD_CYC(BASE_PERIOD_CYC)) u_chk (.clk(clk),
  .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .adc_bit(adc_bit), .eoc_mode(eoc_mode), .charge_complete(charge_complete),
  .input_short(input_short), .dither_enable(dither_enable), .chop(chop), .irq(irq));

// >>> test/tb.sv
// Self-checking bench for the charge counter
`timescale 1ns/1ps
module tb
  import chg_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, hwrite = 1'b0, eoc_mode = 1'b0, rd_dp = 1'b0;
  logic rdy, irq, cc, adc_bit, short_w;
  logic [1:0] htrans = 2'h0, mode = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, x;
  logic [15:0] e16;
  logic [31:0] exp_q[$], msk_q[$];
  int error_cnt = 0, n_compared = 0, cyc = 0, k;
  int m[4] = '{1, 2, 5, 10};
  chg_counter #(.BASE_PERIOD_CYC(200)) dut (.clk(clk), .rst(rst), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy),
    .hrdata(hrdata), .hreadyout(rdy), .hresp(), .adc_bit(adc_bit), .eoc_mode(eoc_mode),
    .charge_complete(cc), .input_short(short_w), .dither_enable(), .chop(), .irq(irq));
  chg_conv_model conv (.clk(clk), .short_in(short_w), .mode(mode), .adc_bit(adc_bit));
  task automatic complete_run();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= !w;
    do @(posedge clk); while (rdy !== 1'b1);
    rd_dp <= 1'b0;
  endtask : xfer
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk);
    exp_q.push_back(e);
    msk_q.push_back(mk);
    xfer(1'b0, a, 32'h0);
  endtask : rd
  task automatic burst(input logic [1:0] md, input int n);
    mode <= md;
    repeat (n) @(posedge clk);
    mode <= 2'h0;
    repeat (5) @(posedge clk);
  endtask : burst
  // Scoreboard side: oldest note against each read data phase
  always @(posedge clk) if (rd_dp && rdy) chk(hrdata & msk_q.pop_front(), exp_q.pop_front());
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial forever #5 clk = ~clk;
  initial begin
    x = $urandom(32'hEFDDF23F);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ADR_CTRL, 32'h80, 32'hFFFFFFFF);
    rd(ADR_SCALE, 32'h111, 32'hFFFFFFFF);
    xfer(1'b1, ADR_SCALE, 32'h8);
    xfer(1'b1, ADR_CTRL, 32'h6);
    burst(2'h1, 44);
    rd(ADR_COUNT, 32'h5, 32'hFFFF);
    xfer(1'b1, ADR_CTRL, 32'h4);
    burst(2'h1, 100);
    rd(ADR_COUNT, 32'h5, 32'hFFFF);
    xfer(1'b1, ADR_CTRL, 32'h6);
    burst(2'h1, 24);
    rd(ADR_COUNT, 32'h8, 32'hFFFF);
    xfer(1'b1, ADR_CTRL, 32'h7);
    rd(ADR_CTRL, 32'h7, 32'hFFFFFFFF);
    repeat (4010) @(posedge clk);
    rd(ADR_CTRL, 32'h6, 32'hFFFFFFFF);
    rd(ADR_COUNT, 32'h0, 32'hFFFF);
    for (int r = 0; r < 4; r++) begin
      k = 1 + $urandom % 3;
      e16 = r[0] ? 16'(-k) : 16'(k);
      xfer(1'b1, ADR_CTRL, 32'(r << 5) | 32'h7);
      repeat (4010) @(posedge clk);
      burst(r[0] ? 2'h2 : 2'h1, 8 * m[r] * k + 4);
      rd(ADR_COUNT, {16'h0, e16}, 32'hFFFF);
    end
    // Steps every 40 samples, so any whole period holds an exact count
    xfer(1'b1, ADR_SCALE, 32'h28);
    xfer(1'b1, ADR_IMASK, 32'h1);
    mode <= 2'h1;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, ADR_CTRL, 32'(i << 7) | 32'h7);
      // First period after a clear lags one count; judge the second
      for (int j = 0; j < 2; j++) begin
        xfer(1'b1, ADR_ISTAT, 32'h3);
        repeat (2) @(posedge clk);
        k = 0;
        while (irq !== 1'b1 && k < 8000) begin
          @(posedge clk);
          k++;
        end
      end
      rd(ADR_CURR, 32'(5 << i), 32'hFFF);
    end
    xfer(1'b1, ADR_IMASK, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    rd(ADR_ISTAT, 32'h1, 32'h1);
    xfer(1'b1, ADR_IMASK, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    xfer(1'b1, ADR_ISTAT, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    xfer(1'b1, ADR_SCALE, 32'h1);
    mode <= 2'h2;
    xfer(1'b1, ADR_CTRL, 32'h7);
    repeat (36000) @(posedge clk);
    rd(ADR_FAULT, 32'h0, 32'hFFFFFFFF);
    repeat (1000) @(posedge clk);
    xfer(1'b1, ADR_CTRL, 32'h4);
    rd(ADR_FAULT, 32'h1, 32'hFFFFFFFF);
    xfer(1'b1, ADR_FAULT, 32'h1);
    rd(ADR_FAULT, 32'h0, 32'hFFFFFFFF);
    xfer(1'b1, ADR_SCALE, 32'h8);
    xfer(1'b1, ADR_CTRL, 32'hF);
    repeat (4010) @(posedge clk);
    burst(2'h1, 200);
    rd(ADR_COUNT, 32'h0, 32'hFFFF);
    xfer(1'b1, ADR_CTRL, 32'h12);
    xfer(1'b1, ADR_CTRL, 32'h16);
    xfer(1'b1, ADR_SCALE, 32'h28);
    xfer(1'b1, ADR_CTRL, 32'h4);
    xfer(1'b1, ADR_THR, 32'h4);
    mode <= 2'h1;
    eoc_mode <= 1'b1;
    xfer(1'b1, ADR_CTRL, 32'h5);
    rd(ADR_CTRL, 32'h4, 32'hFFFFFFFF);
    repeat (700) @(posedge clk);
    chk(32'(cc), 32'h0);
    xfer(1'b1, ADR_THR, 32'h5);
    repeat (500) @(posedge clk);
    chk(32'(cc), 32'h1);
    rd(ADR_ISTAT, 32'h2, 32'h2);
    eoc_mode <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(cc), 32'h0);
    repeat (2) @(posedge clk);
    complete_run();
  end
endmodule : tb
